// File: pvs_consts.svh
// Purpose: offsets, field positions, reset values and timing counts of the pcm voice slot port
// Assumes: included by the package and the port module
// Notes:   byte addresses on the plain register port, one 16-bit register per word
`ifndef PVS_CONSTS_SVH
`define PVS_CONSTS_SVH

// ==========================================================================
// register offsets
`define PVS_OFS_CTRL        8'h00
`define PVS_OFS_CHAN        8'h04
`define PVS_OFS_BURST       8'h08
`define PVS_OFS_STATUS      8'h0c
`define PVS_OFS_TX0         8'h10
`define PVS_OFS_RX0         8'h20

// ==========================================================================
// control field positions
`define PVS_CTRL_EN         0
`define PVS_CTRL_MASTER     1
`define PVS_CTRL_LONG       2
`define PVS_CTRL_WIDE       3
`define PVS_CTRL_RATE_LO    4
`define PVS_CTRL_BURST      7
`define PVS_CTRL_LSB        8
`define PVS_CTRL_OFS_LO     9
`define PVS_CTRL_FILL_LO    11
`define PVS_CTRL_FVAL_LO    13
`define PVS_CHAN_W          5

// ==========================================================================
// reset values
`define PVS_CTRL_RST        16'h0000
`define PVS_CHAN_RST        15'h0000
`define PVS_BURST_RST       8'h01

// ==========================================================================
// timing
`define PVS_SYS_HZ          10000000
`define PVS_RATE_BASE_HZ    128000
`define PVS_HALF_BASE       (`PVS_SYS_HZ / (2 * `PVS_RATE_BASE_HZ))
`define PVS_SLOT_BITS       16
`define PVS_LONG_BITS       3
`define PVS_CHANS           3

`endif

// File: pvs_pkg.sv
// Purpose: types of the pcm voice slot port
// Assumes: pvs_consts.svh
// Notes:   all state of the port lives in one packed struct
`include "pvs_consts.svh"

package pvs_pkg;

  // ========================================================================
  // fill modes for the three spare bits of a transmitted word
  typedef enum logic [1:0] {
    PVS_FILL_ZERO = 2'b00,
    PVS_FILL_ONE  = 2'b01,
    PVS_FILL_SIGN = 2'b10,
    PVS_FILL_PROG = 2'b11
  } pvs_fill_t;

  // ========================================================================
  // whole state of the port
  typedef struct packed {
    logic [2:0]       clkSync;
    logic [2:0]       syncSync;
    logic [1:0]       dinSync;
    logic             syncLast;
    logic [7:0]       divCnt;
    logic             clkOut;
    logic             syncOut;
    logic             dout;
    logic             doutOe_n;
    logic [7:0]       bitCnt;
    logic             startPend;
    logic [15:0]      rxShift;
    logic [15:0]      ctrl;
    logic [14:0]      chan;
    logic [7:0]       burstHalf;
    logic [2:0][12:0] txSample;
    logic [2:0][15:0] rxWord;
    logic [2:0]       rxReady;
    logic [2:0]       txDone;
    logic [15:0]      rdata;
  } pvs_state_t;

endpackage

// File: pvs_pcm_port.sv
// Purpose: time-slotted pcm voice port, three full-duplex channels on one bus
// Assumes: sys_clk 10 MHz; pcm pins arrive from outside and are synchronised
// Notes:   bit clock edges are found by sampling, so the bit clock must be
//          well below a quarter of sys_clk
//
// Functional notes
// - up to three full-duplex channels share bus
// - frame at 8 or 16 kHz, max 16 slots
// - slot count follows selected bit-clock rate
// - channel transmits and receives in same slot
// - data output released on unowned slots
// - release after falling edge in last bit
// - short and long sync, master or slave
// - short sync one bit wide, rising-aligned
// - slave samples sync high on falling edge
// - slot zero starts at following rising edge
// - long sync three bits from slot zero
// - 13 of 16 word bits carry sample
// - sample position and bit order configurable
// - spare bits ignored in, filled out selectably
// - reset format left-justified, msb first
// - burst mode runs bus much faster
// - master drives clock and sync, slave receives
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`include "pvs_consts.svh"
module pvs_pcm_port
  import pvs_pkg::*;
(
  // clock, reset, enable
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  // pcm bit clock pin
  input  wire logic        pcmClkIn,
  output logic             pcmClkOut,
  output logic             pcmClkOe_n,
  // pcm frame sync pin
  input  wire logic        pcmSyncIn,
  output logic             pcmSyncOut,
  output logic             pcmSyncOe_n,
  // pcm data pins
  input  wire logic        pcmDin,
  output logic             pcmDout,
  output logic             pcmDoutOe_n
);

  // ==========================================================================
  // state
  localparam pvs_state_t ST_RST = '{
    doutOe_n:  1'b1,
    ctrl:      `PVS_CTRL_RST,
    chan:      `PVS_CHAN_RST,
    burstHalf: `PVS_BURST_RST,
    default:   '0
  };

  pvs_state_t st_ff;
  pvs_state_t nxt_st;

  // ==========================================================================
  // decoded control
  logic        enable;
  logic        master;
  logic        longSync;
  logic        wide;
  logic [2:0]  rateSel;
  logic        burst;
  logic        lsbFirst;
  logic [1:0]  wordOfs;
  pvs_fill_t   fillMode;
  logic [2:0]  fillVal;
  logic [2:0]  slotLog;
  logic [7:0]  lastBit;
  logic [7:0]  halfPer;
  logic [7:0]  nextBit;
  logic        riseEv;
  logic        fallEv;
  logic        syncSeen;

  assign enable   = st_ff.ctrl[`PVS_CTRL_EN];
  assign master   = st_ff.ctrl[`PVS_CTRL_MASTER];
  assign longSync = st_ff.ctrl[`PVS_CTRL_LONG];
  assign wide     = st_ff.ctrl[`PVS_CTRL_WIDE];
  assign rateSel  = st_ff.ctrl[`PVS_CTRL_RATE_LO +: 3];
  assign burst    = st_ff.ctrl[`PVS_CTRL_BURST];
  assign lsbFirst = st_ff.ctrl[`PVS_CTRL_LSB];
  assign wordOfs  = st_ff.ctrl[`PVS_CTRL_OFS_LO +: 2];
  assign fillMode = pvs_fill_t'(st_ff.ctrl[`PVS_CTRL_FILL_LO +: 2]);
  assign fillVal  = st_ff.ctrl[`PVS_CTRL_FVAL_LO +: 3];

  // ==========================================================================
  // frame geometry: slots = rate / (frame rate * 16), capped at 16
  always_comb
  begin
    slotLog = 3'h0;
    if (rateSel > 3'h4)
    begin
      slotLog = 3'h4;
    end
    else if (wide && rateSel != 3'h0)
    begin
      slotLog = rateSel - 3'h1;
    end
    else if (!wide)
    begin
      slotLog = rateSel;
    end
  end

  assign lastBit = 8'((9'h010 << slotLog) - 9'h001);

  // burst swaps in a short host-chosen half period; only a register write sets it
  assign halfPer = burst ? st_ff.burstHalf
                         : 8'(`PVS_HALF_BASE >> rateSel);

  // ==========================================================================
  // bit clock edges: own divider in master, sampled pin in slave
  always_comb
  begin
    riseEv = 1'b0;
    fallEv = 1'b0;
    if (enable && master)
    begin
      riseEv = (st_ff.divCnt == 8'h00) && !st_ff.clkOut;
      fallEv = (st_ff.divCnt == 8'h00) && st_ff.clkOut;
    end
    else if (enable)
    begin
      riseEv = st_ff.clkSync[1] && !st_ff.clkSync[2];
      fallEv = !st_ff.clkSync[1] && st_ff.clkSync[2];
    end
  end

  assign syncSeen = st_ff.syncSync[1];

  // bit counter value after the coming rising edge
  always_comb
  begin
    nextBit = st_ff.bitCnt + 8'h01;
    // a pending start also opens bit zero on the first edge after enable
    if (st_ff.startPend)
    begin
      nextBit = 8'h00;
    end
    else if (st_ff.bitCnt >= lastBit)
    begin
      nextBit = 8'h00;
    end
  end

  // ==========================================================================
  // per-channel slot match and word formatting
  logic [2:0]       txHit;
  logic [2:0]       rxHit;
  logic [2:0][15:0] txWord;
  logic [2:0][15:0] rxSample;

  genvar ch;
  generate
    for (ch = 0; ch < `PVS_CHANS; ch = ch + 1)
    begin : g_chan
      logic        chEn;
      logic [3:0]  chSlot;
      logic [2:0]  pad;
      logic [31:0] txDbl;
      logic [15:0] txRot;
      logic [15:0] txRev;
      logic [15:0] rxWire;
      logic [15:0] rxRev;
      logic [31:0] rxDbl;

      assign chEn   = st_ff.chan[ch * `PVS_CHAN_W + 4];
      assign chSlot = st_ff.chan[ch * `PVS_CHAN_W +: 4];
      // tx and rx use one slot index per channel
      assign txHit[ch] = chEn && (chSlot == nextBit[7:4]);
      assign rxHit[ch] = chEn && (chSlot == st_ff.bitCnt[7:4]);

      always_comb
      begin
        case (fillMode)
          PVS_FILL_ZERO: pad = 3'h0;
          PVS_FILL_ONE:  pad = 3'h7;
          PVS_FILL_SIGN: pad = {3{st_ff.txSample[ch][12]}};
          PVS_FILL_PROG: pad = fillVal;
          default:       pad = 3'h0;
        endcase
      end

      // rotating {sample, pad} moves the 13 bits down; pad bits wrap to the top
      assign txDbl      = {st_ff.txSample[ch], pad, st_ff.txSample[ch], pad} >> wordOfs;
      assign txRot      = txDbl[15:0];
      assign txRev      = {<<{txRot}};
      assign txWord[ch] = lsbFirst ? txRev : txRot;

      // spare bits fall away on receive
      assign rxRev         = {<<{st_ff.rxWord[ch]}};
      assign rxWire        = lsbFirst ? rxRev : st_ff.rxWord[ch];
      assign rxDbl         = {rxWire, rxWire} << wordOfs;
      assign rxSample[ch]  = {{3{rxDbl[31]}}, rxDbl[31:19]};
    end
  endgenerate

  // lowest channel wins if software maps two channels onto one slot
  logic [1:0] txSel;
  logic [1:0] rxSel;

  always_comb
  begin
    txSel = 2'h0;
    rxSel = 2'h0;
    if (txHit[0])
    begin
      txSel = 2'h0;
    end
    else if (txHit[1])
    begin
      txSel = 2'h1;
    end
    else if (txHit[2])
    begin
      txSel = 2'h2;
    end
    if (rxHit[0])
    begin
      rxSel = 2'h0;
    end
    else if (rxHit[1])
    begin
      rxSel = 2'h1;
    end
    else if (rxHit[2])
    begin
      rxSel = 2'h2;
    end
  end

  // ==========================================================================
  // next state
  logic [2:0] rxSet;
  logic [2:0] txSet;

  always_comb
  begin
    nxt_st = st_ff;
    rxSet  = 3'h0;
    txSet  = 3'h0;

    // pins pass two flops before anything looks at them
    nxt_st.clkSync  = {st_ff.clkSync[1:0], pcmClkIn};
    nxt_st.syncSync = {st_ff.syncSync[1:0], pcmSyncIn};
    nxt_st.dinSync  = {st_ff.dinSync[0], pcmDin};

    // bit clock divider
    if (!(enable && master))
    begin
      nxt_st.divCnt  = 8'h00;
      nxt_st.clkOut  = 1'b0;
      nxt_st.syncOut = 1'b0;
    end
    else if (st_ff.divCnt == 8'h00)
    begin
      nxt_st.divCnt = (halfPer == 8'h00) ? 8'h00 : halfPer - 8'h01;
      nxt_st.clkOut = !st_ff.clkOut;
    end
    else
    begin
      nxt_st.divCnt = st_ff.divCnt - 8'h01;
    end

    if (!enable)
    begin
      nxt_st.bitCnt    = 8'h00;
      nxt_st.startPend = 1'b1;
      nxt_st.doutOe_n  = 1'b1;
    end

    // rising edge: advance bit, launch tx bit, master sync
    if (riseEv)
    begin
      nxt_st.bitCnt    = nextBit;
      nxt_st.startPend = 1'b0;
      if (|txHit)
      begin
        nxt_st.dout     = txWord[txSel][4'hf - nextBit[3:0]];
        nxt_st.doutOe_n = 1'b0;
        if (nextBit[3:0] == 4'hf)
        begin
          txSet[txSel] = 1'b1;
        end
      end
      else
      begin
        nxt_st.doutOe_n = 1'b1;
      end
      // a slave leaves its sync output at rest; only the master times frames
      if (longSync && master)
      begin
        nxt_st.syncOut = nextBit < 8'(`PVS_LONG_BITS);
      end
      else if (master)
      begin
        nxt_st.syncOut = nextBit == lastBit;
      end
    end

    // falling edge: sample data, release driver, slave sync detect
    if (fallEv)
    begin
      nxt_st.rxShift = {st_ff.rxShift[14:0], st_ff.dinSync[1]};
      if ((|rxHit) && st_ff.bitCnt[3:0] == 4'hf)
      begin
        nxt_st.rxWord[rxSel] = {st_ff.rxShift[14:0], st_ff.dinSync[1]};
        rxSet[rxSel]         = 1'b1;
      end
      if (st_ff.bitCnt[3:0] == 4'hf)
      begin
        nxt_st.doutOe_n = 1'b1;
      end
      nxt_st.syncLast = syncSeen;
      if (!master && !longSync && syncSeen)
      begin
        nxt_st.startPend = 1'b1;
      end
      // long sync first seen high inside bit zero
      if (!master && longSync && syncSeen && !st_ff.syncLast)
      begin
        nxt_st.bitCnt = 8'h00;
      end
    end

    // register writes
    if (regWr)
    begin
      case (regAddr)
        `PVS_OFS_CTRL:   nxt_st.ctrl = regWdata;
        `PVS_OFS_CHAN:   nxt_st.chan = regWdata[14:0];
        `PVS_OFS_BURST:  nxt_st.burstHalf = regWdata[7:0];
        `PVS_OFS_TX0:    nxt_st.txSample[0] = regWdata[12:0];
        `PVS_OFS_TX0 + 8'h04: nxt_st.txSample[1] = regWdata[12:0];
        `PVS_OFS_TX0 + 8'h08: nxt_st.txSample[2] = regWdata[12:0];
        default: ;
      endcase
    end

    // sticky flags: write one clears, a new event in the same cycle wins
    if (regWr && regAddr == `PVS_OFS_STATUS)
    begin
      nxt_st.rxReady = st_ff.rxReady & ~regWdata[2:0];
      nxt_st.txDone  = st_ff.txDone & ~regWdata[5:3];
    end
    nxt_st.rxReady = nxt_st.rxReady | rxSet;
    nxt_st.txDone  = nxt_st.txDone | txSet;

    // reads answer in the following cycle
    nxt_st.rdata = 16'h0000;
    if (regRd)
    begin
      case (regAddr)
        `PVS_OFS_CTRL:   nxt_st.rdata = st_ff.ctrl;
        `PVS_OFS_CHAN:   nxt_st.rdata = {1'b0, st_ff.chan};
        `PVS_OFS_BURST:  nxt_st.rdata = {8'h00, st_ff.burstHalf};
        `PVS_OFS_STATUS: nxt_st.rdata = {st_ff.bitCnt, 1'b0, !st_ff.doutOe_n,
                                         st_ff.txDone, st_ff.rxReady};
        `PVS_OFS_TX0:    nxt_st.rdata = {3'h0, st_ff.txSample[0]};
        `PVS_OFS_TX0 + 8'h04: nxt_st.rdata = {3'h0, st_ff.txSample[1]};
        `PVS_OFS_TX0 + 8'h08: nxt_st.rdata = {3'h0, st_ff.txSample[2]};
        `PVS_OFS_RX0:    nxt_st.rdata = rxSample[0];
        `PVS_OFS_RX0 + 8'h04: nxt_st.rdata = rxSample[1];
        `PVS_OFS_RX0 + 8'h08: nxt_st.rdata = rxSample[2];
        default:         nxt_st.rdata = 16'h0000;
      endcase
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_ff <= ST_RST;
    end
    else if (clkEn)
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // outputs
  assign regRdata    = st_ff.rdata;
  assign pcmClkOut   = st_ff.clkOut;
  assign pcmClkOe_n  = !(enable && master);
  assign pcmSyncOut  = st_ff.syncOut;
  assign pcmSyncOe_n = !(enable && master);
  assign pcmDout     = st_ff.dout;
  assign pcmDoutOe_n = st_ff.doutOe_n;

endmodule

// File: pvs_port_checker.sv
// Purpose: port-level assertions of the pcm voice slot port
// Assumes: control register mirrored from the register strobes
// Notes:   master timing judged at rate 0 only, where a half bit is 39 cycles
`include "pvs_consts.svh"

module pvs_port_checker
  import pvs_pkg::*;
(
  // clock, reset, enable
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        clkEn,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWdata,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdata,
  // pcm pins
  input wire logic        pcmClkIn,
  input wire logic        pcmClkOut,
  input wire logic        pcmClkOe_n,
  input wire logic        pcmSyncIn,
  input wire logic        pcmSyncOut,
  input wire logic        pcmSyncOe_n,
  input wire logic        pcmDin,
  input wire logic        pcmDout,
  input wire logic        pcmDoutOe_n
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // control mirror
  logic [15:0] ctrlMirror_ff;
  logic        isEn;
  logic        mst0;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrlMirror_ff <= `PVS_CTRL_RST;
    else if (clkEn && regWr && regAddr == `PVS_OFS_CTRL)
      ctrlMirror_ff <= regWdata;
  end

  assign isEn = ctrlMirror_ff[0];
  // burst and faster rates leave the fixed-count checks alone
  assign mst0 = isEn && ctrlMirror_ff[1] && ctrlMirror_ff[7:4] == 4'h0;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  pin_direction_a: assert property (pcmClkOe_n == !(isEn && ctrlMirror_ff[1]) &&
    pcmSyncOe_n == pcmClkOe_n) else $error("clock or sync pin direction wrong");
  off_quiet_a: assert property (!isEn && !$past(isEn) |-> pcmDoutOe_n)
    else $error("data driven while disabled");
  slave_tx_rise_a: assert property ($changed(pcmDout) && !pcmDoutOe_n && pcmClkOe_n
    |-> $past(pcmClkIn, 2)) else $error("slave data moved outside high clock");
  slave_release_a: assert property ($rose(pcmDoutOe_n) && pcmClkOe_n
    |-> !$past(pcmClkIn, 2)) else $error("release not after falling edge");
  mst_half_a: assert property ($rose(pcmClkOut) && mst0
    |-> ##38 pcmClkOut ##1 !pcmClkOut) else $error("master half period wrong");
  mst_short_a: assert property ($rose(pcmSyncOut) && mst0 && !ctrlMirror_ff[2]
    |-> ##77 pcmSyncOut ##1 !pcmSyncOut) else $error("short sync width wrong");
  mst_long_a: assert property ($rose(pcmSyncOut) && mst0 && ctrlMirror_ff[2]
    |-> ##233 pcmSyncOut ##1 !pcmSyncOut) else $error("long sync width wrong");
  sync_align_a: assert property ($rose(pcmSyncOut) |-> pcmClkOut)
    else $error("sync not aligned to rising clock");
  mst_tx_rise_a: assert property ($changed(pcmDout) && !pcmDoutOe_n && !pcmClkOe_n
    |-> pcmClkOut) else $error("master data moved outside high clock");
endmodule

bind pvs_pcm_port pvs_port_checker chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .pcmClkIn(pcmClkIn), .pcmClkOut(pcmClkOut), .pcmClkOe_n(pcmClkOe_n),
  .pcmSyncIn(pcmSyncIn), .pcmSyncOut(pcmSyncOut), .pcmSyncOe_n(pcmSyncOe_n),
  .pcmDin(pcmDin), .pcmDout(pcmDout), .pcmDoutOe_n(pcmDoutOe_n)
);

// File: pvs_codec_model.sv
// Purpose: behavioural pcm codec mastering bit clock and frame sync
// Assumes: 800 ns bit period, owns one slot of the frame
// Notes:   outside its slot din shows the inverse of its last bit
module pvs_codec_model (
  // control
  input  wire logic        run,
  input  wire logic        longSync,
  input  wire logic [4:0]  slots,
  input  wire logic [3:0]  mySlot,
  input  wire logic [15:0] txWord,
  // device data pin
  input  wire logic        dout,
  input  wire logic        doutOe_n,
  // link
  output logic             bitClk,
  output logic             frameSync,
  output logic             din,
  // observation
  output logic      [15:0] capWord,
  output int               capCnt,
  output int               strayCnt
);
  timeunit 1ns;
  timeprecision 1ns;

  int          bitNo;
  logic [15:0] cap;

  initial
  begin
    bitClk = 1'b0;
    frameSync = 1'b0;
    din = 1'b0;
    capWord = 16'h0000;
    cap = 16'h0000;
    capCnt = 0;
    strayCnt = 0;
    bitNo = 0;
    forever
    begin
      if (!run)
      begin
        // clock stands still while run is low, low
        bitClk = 1'b0;
        frameSync = 1'b0;
        bitNo = 0;
        #100;
      end
      else
      begin
        bitClk = 1'b1;
        frameSync = longSync ? (bitNo < 3) : (bitNo == 16 * slots - 1);
        din = (bitNo / 16 == mySlot) ? txWord[15 - bitNo % 16] : ~din;
        #400 bitClk = 1'b0;
        // sample late in the low half, past the device's synchroniser lag
        #200;
        if (bitNo / 16 == mySlot)
          cap[15 - bitNo % 16] = doutOe_n ? 1'bx : dout;
        else if (doutOe_n === 1'b0)
          strayCnt++;
        if (bitNo / 16 == mySlot && bitNo % 16 == 15)
        begin
          capWord = cap;
          capCnt++;
        end
        #200 bitNo = (bitNo + 1) % (16 * slots);
      end
    end
  end
endmodule

// File: test_pcm_voice_slot_interface.sv
// Purpose: self-checking bench of the pcm voice slot port
// Assumes: codec model masters the link in slave scenarios
// Notes:   master timing mostly judged by the bound checker
`include "pvs_consts.svh"

`define CHECK(nm, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("wrong value %s expected %h seen %h", nm, exp, got); \
    end \
  end

module test_pcm_voice_slot_interface;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] CODEC_WORD = 16'hb5a7;

  logic        sys_clk;
  logic        rst_n;
  logic        clkEn;
  logic [7:0]  regAddr;
  logic [15:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [15:0] regRdata;
  logic        pcmClkIn;
  logic        pcmClkOut;
  logic        pcmClkOe_n;
  logic        pcmSyncIn;
  logic        pcmSyncOut;
  logic        pcmSyncOe_n;
  logic        pcmDin;
  logic        pcmDout;
  logic        pcmDoutOe_n;
  logic        run;
  logic        longSync;
  logic        mClk;
  logic        mSync;
  logic [15:0] capWord;
  int          capCnt;
  int          strayCnt;
  int          fails;
  int          check_count;

  // ==========================================================================
  // wiring: each pin level follows whoever drives it
  assign pcmClkIn  = !pcmClkOe_n ? pcmClkOut : mClk;
  assign pcmSyncIn = !pcmSyncOe_n ? pcmSyncOut : mSync;

  pvs_pcm_port dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .pcmClkIn(pcmClkIn), .pcmClkOut(pcmClkOut), .pcmClkOe_n(pcmClkOe_n),
    .pcmSyncIn(pcmSyncIn), .pcmSyncOut(pcmSyncOut), .pcmSyncOe_n(pcmSyncOe_n),
    .pcmDin(pcmDin), .pcmDout(pcmDout), .pcmDoutOe_n(pcmDoutOe_n)
  );

  pvs_codec_model codec (
    .run(run), .longSync(longSync), .slots(5'h02), .mySlot(4'h1), .txWord(CODEC_WORD),
    .dout(pcmDout), .doutOe_n(pcmDoutOe_n), .bitClk(mClk), .frameSync(mSync),
    .din(pcmDin), .capWord(capWord), .capCnt(capCnt), .strayCnt(strayCnt)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ==========================================================================
  // helpers
  task results;
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task bail;
    fails++;
    results;
  endtask

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask

  task waitCaps(input int k);
    int c0;
    int n;
    c0 = capCnt;
    n = 0;
    while (capCnt < c0 + k && n < 4000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 4000)
      bail;
  endtask

  task halfPeriod(output int n);
    int k;
    k = 0;
    n = 0;
    while (pcmClkOut !== 1'b0 && k < 200)
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pcmClkOut !== 1'b1 && k < 200)
    begin
      @(posedge sys_clk);
      k++;
    end
    while (pcmClkOut === 1'b1 && n < 200)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (k >= 200)
      bail;
  endtask

  // disable only just after a clock fall, so no pulse is cut short
  task quiesce;
    int n;
    n = 0;
    while (pcmSyncOut !== 1'b1 && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    while ((pcmSyncOut !== 1'b0 || pcmClkOut !== 1'b1) && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pcmClkOut !== 1'b0 && n < 3000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 3000)
      bail;
    wr(`PVS_OFS_CTRL, 16'h0000);
  endtask

  task runSlave(input logic [15:0] c, input logic lng);
    longSync <= lng;
    wr(`PVS_OFS_CHAN, 16'h0011);
    wr(`PVS_OFS_CTRL, c);
    run <= 1'b1;
    waitCaps(3);
  endtask

  task stopSlave;
    run <= 1'b0;
    repeat (20) @(posedge sys_clk);
    wr(`PVS_OFS_CTRL, 16'h0000);
  endtask

  function automatic logic [15:0] fmtWord(input logic [12:0] s, input logic [1:0] ofs,
                                          input logic lsb, input logic [1:0] fill,
                                          input logic [2:0] fv);
    logic [2:0]  pad;
    logic [15:0] w;
    pad = (fill == 2'h0) ? 3'h0 : (fill == 2'h1) ? 3'h7 : (fill == 2'h2) ? {3{s[12]}} : fv;
    w = {s, pad};
    w = (w >> ofs) | (w << (16 - ofs));
    if (lsb)
      w = {<<{w}};
    return w;
  endfunction

  // ==========================================================================
  // scenarios
  task sc_regs;
    logic [15:0] v;
    rd(`PVS_OFS_CTRL, v);
    `CHECK("ctrl reset", `PVS_CTRL_RST, v)
    rd(`PVS_OFS_BURST, v);
    `CHECK("burst reset", 16'h0001, v)
    rd(8'h3c, v);
    `CHECK("unmapped read", 16'h0000, v)
    @(posedge sys_clk);
    clkEn <= 1'b0;
    wr(`PVS_OFS_CHAN, 16'h7fff);
    clkEn <= 1'b1;
    rd(`PVS_OFS_CHAN, v);
    `CHECK("frozen write lost", 16'h0000, v)
    wr(`PVS_OFS_TX0, 16'h1a5b);
    rd(`PVS_OFS_TX0, v);
    `CHECK("tx sample", 16'h1a5b, v)
  endtask

  task sc_short;
    logic [15:0] v;
    int          s0;
    runSlave(16'h0011, 1'b0);
    s0 = strayCnt;
    waitCaps(1);
    `CHECK("short tx word", {13'h1a5b, 3'h0}, capWord)
    `CHECK("stray drive", s0, strayCnt)
    rd(`PVS_OFS_RX0, v);
    `CHECK("rx sample", {{3{CODEC_WORD[15]}}, CODEC_WORD[15:3]}, v)
    rd(`PVS_OFS_STATUS, v);
    `CHECK("rx ready", 1'b1, v[0])
    stopSlave;
  endtask

  task sc_long;
    runSlave(16'h0015, 1'b1);
    `CHECK("long tx word", {13'h1a5b, 3'h0}, capWord)
    stopSlave;
    runSlave(16'h0029, 1'b0);
    `CHECK("wide frame tx word", {13'h1a5b, 3'h0}, capWord)
    stopSlave;
  endtask

  task sc_format;
    logic [15:0] c;
    runSlave(16'h0011, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      c = 16'ha011 | (16'(i & 1) << 8) | (16'(i) << 9) | (16'(i) << 11);
      wr(`PVS_OFS_CTRL, c);
      waitCaps(2);
      `CHECK("format", fmtWord(13'h1a5b, 2'(i), 1'(i), 2'(i), 3'h5), capWord)
    end
    stopSlave;
  endtask

  task sc_master(input logic [15:0] c);
    int n;
    wr(`PVS_OFS_CHAN, 16'h0010);
    wr(`PVS_OFS_CTRL, c);
    // two whole frames pass under the checker
    repeat (2600) @(posedge sys_clk);
    `CHECK("clock pin driven", 1'b0, pcmClkOe_n)
    halfPeriod(n);
    `CHECK("master half period", 39, n)
    quiesce;
  endtask

  task sc_burst;
    int n;
    wr(`PVS_OFS_CHAN, 16'h0000);
    wr(`PVS_OFS_BURST, 16'h0002);
    wr(`PVS_OFS_CTRL, 16'h0003);
    halfPeriod(n);
    `CHECK("no burst unasked", 39, n)
    quiesce;
    wr(`PVS_OFS_CTRL, 16'h0083);
    halfPeriod(n);
    `CHECK("burst half period", 2, n)
    quiesce;
  endtask

  initial
  begin
    rst_n = 1'b0;
    clkEn = 1'b1;
    regAddr = 8'h00;
    regWdata = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    run = 1'b0;
    longSync = 1'b0;
    fails = 0;
    check_count = 0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    sc_regs;
    sc_short;
    sc_long;
    sc_format;
    sc_master(16'h0003);
    sc_master(16'h0007);
    sc_burst;
    results;
  end
endmodule
